// file: ocg_pkg.sv
// Constants and state types shared by the oscillator clock gating block.
// Assumes a single 50 MHz system clock with a synchronous active-high reset.
package ocg_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ = 50_000_000;
  localparam int RC_FREQ_HZ = 64_000;
  localparam int RC_CNT_W = 9;
  localparam int RC_HALF_CYC = CLOCK_HZ / (2 * RC_FREQ_HZ);

  // ----------------------------------------------------------------------
  // State layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] xtal_sync;
    logic [1:0] pll_sync;
    logic pll_dly;
    logic xg_dly;
    logic [RC_CNT_W-1:0] rc_cnt;
    logic rc_lvl;
    logic xtal_div2;
    logic pll_div2;
    logic base;
    logic bus;
    logic amp_out;
  } ocg_state_t;

  typedef struct packed {
    logic en_held;
    logic gclk;
  } ocg_gate_state_t;

  localparam ocg_state_t STATE_RESET = '0;
  localparam ocg_gate_state_t GATE_RESET = '0;

endpackage : ocg_pkg

// file: ocg_gate_if.sv
// Carrier between the top module and one glitch-free clock gate.
// Assumes source and enable are levels on the system clock.
`timescale 1ns/10ps
interface ocg_gate_if;
  logic src;
  logic en;
  logic gclk;
  modport gate (input src, input en, output gclk);
  modport user (output src, output en, input gclk);
endinterface : ocg_gate_if

// file: ocg_gate.sv
// Glitch-free gate for a clock carried as a sampled level.
// Assumes the source level is synchronous to the system clock.
`timescale 1ns/10ps
module ocg_gate (
  // System
  input wire logic clock,
  input wire logic rst,
  // Gated clock carrier
  ocg_gate_if.gate g
);

  ocg_pkg::ocg_gate_state_t s_r;
  ocg_pkg::ocg_gate_state_t s_nxt;

  // The enable is only taken while the source is low, so the output never
  // shows a shortened high or low phase.
  always_comb
  begin
    s_nxt = s_r;
    if (!g.src)
    begin
      s_nxt.en_held = g.en;
    end
    s_nxt.gclk = g.src & s_nxt.en_held;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= ocg_pkg::GATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign g.gclk = s_r.gclk;

endmodule : ocg_gate

// file: ocg_top.sv
// Digital control of the oscillator module: RC clock, crystal clock,
// PLL reference copy, base and bus clocks, with stop-mode gating.
// Assumes pins are asynchronous and all clocks are carried as levels.
//
// What this block does
// - Monitor clock comes only from RC oscillator.
// - RC clock runs after any reset.
// - RC clock free-runs at nominal 64 kHz.
// - RC disable bit stops RC in stop.
// - System enable gates crystal; gates RC only in stop with RC disable set.
// - RC clock feeds system module and monitor.
// - Crystal clock feeds generator and peripherals.
// - Separate buffered crystal copy is PLL reference.
// - Wait behaves exactly like run.
// - Stop removes enable, crystal clocks stop.
// - Keep-alive bit keeps crystal running in stop.
// - Break state leaves all clocks running.
// - Base is crystal/2 or PLL/2; bus half.
`timescale 1ns/10ps
module ocg_top #(
  parameter int CLK_HZ = ocg_pkg::CLOCK_HZ,
  parameter int RC_HZ = ocg_pkg::RC_FREQ_HZ
) (
  // System
  input wire logic clock,
  input wire logic rst,
  // Pins
  input wire logic crystal_amp_input,
  input wire logic pll_clock_in,
  output logic crystal_amp_output,
  // From the system integration module
  input wire logic oscillator_enable_from_sysint,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic break_mode,
  input wire logic stop_rc_disable,
  input wire logic stop_crystal_keepalive,
  input wire logic base_select_pll,
  // Clock outputs
  output logic internal_rc_clock,
  output logic monitor_clock,
  output logic sysint_clock,
  output logic crystal_clock_out,
  output logic pll_reference_clock,
  output logic base_clock_out,
  output logic bus_clock_out
);

  // ----------------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------------
  localparam int HALF = CLK_HZ / (2 * RC_HZ);
  localparam int RC_W = ocg_pkg::RC_CNT_W;
  localparam logic [ocg_pkg::RC_CNT_W-1:0] RC_LAST = RC_W'(HALF - 1);

  generate
    if (HALF < 2 || HALF > (1 << ocg_pkg::RC_CNT_W))
    begin : g_bad_rate
      $error("RC divider cannot serve this clock rate");
    end
  endgenerate

  ocg_pkg::ocg_state_t s_r;
  ocg_pkg::ocg_state_t s_nxt;
  logic xtal_on;
  logic rc_on;

  ocg_gate_if rc_g ();
  ocg_gate_if xt_g ();
  ocg_gate_if rf_g ();

  // ----------------------------------------------------------------------
  // Enables
  // ----------------------------------------------------------------------
  // Wait is deliberately not a term: it must not change any clock.
  always_comb
  begin
    xtal_on = oscillator_enable_from_sysint
              | (stop_mode & stop_crystal_keepalive)
              | break_mode;
    rc_on = oscillator_enable_from_sysint
            | ~stop_mode
            | ~stop_rc_disable
            | break_mode;
  end

  assign rc_g.src = s_r.rc_lvl;
  assign rc_g.en = rc_on;
  assign xt_g.src = s_r.xtal_sync[1];
  assign xt_g.en = xtal_on;
  assign rf_g.src = s_r.xtal_sync[1];
  assign rf_g.en = xtal_on;

  ocg_gate u_rc_gate (.clock(clock), .rst(rst), .g(rc_g.gate));
  ocg_gate u_xt_gate (.clock(clock), .rst(rst), .g(xt_g.gate));
  ocg_gate u_rf_gate (.clock(clock), .rst(rst), .g(rf_g.gate));

  // ----------------------------------------------------------------------
  // Dividers and synchronisers
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.xtal_sync = {s_r.xtal_sync[0], crystal_amp_input};
    s_nxt.pll_sync = {s_r.pll_sync[0], pll_clock_in};
    s_nxt.pll_dly = s_r.pll_sync[1];
    s_nxt.xg_dly = xt_g.gclk;
    // The RC divider restarts at reset and then never stops counting.
    if (s_r.rc_cnt == RC_LAST)
    begin
      s_nxt.rc_cnt = '0;
      s_nxt.rc_lvl = ~s_r.rc_lvl;
    end
    else
    begin
      s_nxt.rc_cnt = s_r.rc_cnt + 1'b1;
    end
    if (xt_g.gclk && !s_r.xg_dly)
    begin
      s_nxt.xtal_div2 = ~s_r.xtal_div2;
    end
    if (s_r.pll_sync[1] && !s_r.pll_dly)
    begin
      s_nxt.pll_div2 = ~s_r.pll_div2;
    end
    // Switching the selector mid-phase can shorten one base phase; software
    // is expected to change it only while the generator is idle.
    s_nxt.base = base_select_pll ? s_r.pll_div2 : s_r.xtal_div2;
    if (s_nxt.base && !s_r.base)
    begin
      s_nxt.bus = ~s_r.bus;
    end
    s_nxt.amp_out = xtal_on & ~s_r.xtal_sync[1];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= ocg_pkg::STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign internal_rc_clock = rc_g.gclk;
  assign monitor_clock = rc_g.gclk;
  assign sysint_clock = rc_g.gclk;
  assign crystal_clock_out = xt_g.gclk;
  assign pll_reference_clock = rf_g.gclk;
  assign base_clock_out = s_r.base;
  assign bus_clock_out = s_r.bus;
  assign crystal_amp_output = s_r.amp_out;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  monitor_from_rc_a: assert property (@(posedge clock) disable iff (rst)
    monitor_clock == internal_rc_clock && sysint_clock == internal_rc_clock)
    else $error("monitor clock differs from RC clock");

  rc_half_period_a: assert property (@(posedge clock) disable iff (rst)
    (s_r.rc_cnt == RC_LAST) |=> $changed(s_r.rc_lvl) ##1 $stable(s_r.rc_lvl))
    else $error("RC level did not toggle at end of half period");

  rc_stop_disable_a: assert property (@(posedge clock) disable iff (rst)
    $rose(internal_rc_clock) |-> $past(rc_g.en) || $past(rc_g.en, 2))
    else $error("RC clock rose while disabled");

  rc_run_keeps_a: assert property (@(posedge clock) disable iff (rst)
    !stop_mode |-> rc_on)
    else $error("RC enable dropped outside stop");

  xtal_gate_en_a: assert property (@(posedge clock) disable iff (rst)
    $rose(crystal_clock_out) |-> $past(xtal_on) || $past(xtal_on, 2))
    else $error("crystal clock rose while gated off");

  keepalive_stop_a: assert property (@(posedge clock) disable iff (rst)
    (stop_mode && stop_crystal_keepalive) |-> xtal_on)
    else $error("keep-alive did not hold crystal enable");

  break_runs_a: assert property (@(posedge clock) disable iff (rst)
    break_mode |-> (xtal_on && rc_on))
    else $error("break state gated a clock");

  wait_as_run_a: assert property (@(posedge clock) disable iff (rst)
    (wait_mode && !stop_mode) |->
      (rc_on && (xtal_on == (oscillator_enable_from_sysint | break_mode))))
    else $error("wait state changed a clock enable");

  ref_copy_a: assert property (@(posedge clock) disable iff (rst)
    pll_reference_clock == crystal_clock_out)
    else $error("reference copy differs from crystal clock");

  whole_phase_a: assert property (@(posedge clock) disable iff (rst)
    $fell(crystal_clock_out) |-> !$past(s_r.xtal_sync[1]))
    else $error("crystal clock cut during high phase");

  bus_half_base_a: assert property (@(posedge clock) disable iff (rst)
    $changed(bus_clock_out) |-> $rose(base_clock_out))
    else $error("bus clock changed without base rising edge");

endmodule : ocg_top

// file: ocg_sysint_model.sv
// Partner model: system integration side and the free-running pin sources.
// Assumes the bench clock; pin edges fall between clock edges.
`timescale 1ns/10ps
module ocg_sysint_model (
  // Control from the bench
  input wire logic en_allow,
  input wire logic stop_mode,
  // Towards the block
  output logic crystal_pin,
  output logic pll_pin,
  output logic osc_en
);
  // The oscillator enable drops whenever stop is entered.
  assign osc_en = en_allow & ~stop_mode;
  // The sources know nothing of the modes, so they are offset from the system clock.
  initial
  begin
    crystal_pin = 1'b0;
    #5;
    forever #80 crystal_pin = ~crystal_pin;
  end
  initial
  begin
    pll_pin = 1'b0;
    #7;
    forever #120 pll_pin = ~pll_pin;
  end
endmodule : ocg_sysint_model

// file: tb_ocg_top.sv
// Testbench for the clock gating block: mode mixes, counting clock rises.
// Assumes the partner model supplies pins and the oscillator enable.
`timescale 1ns/10ps
module tb_ocg_top;
  typedef struct packed {logic x; logic r; logic s;} ocg_exp_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic en_allow = 1'b0, stop_mode = 1'b0, wait_mode = 1'b0, break_mode = 1'b0;
  logic rc_dis = 1'b0, keep = 1'b0, sel = 1'b0, win = 1'b0, win_end = 1'b0;
  logic xpin, ppin, osc_en, rc, mon, sysc, xclk, pref, base, bus, amp;
  logic px = 1'b0, pr = 1'b0, pb = 1'b0, pu = 1'b0, pa = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  int nx = 0, nr = 0, nb = 0, nu = 0, na = 0, xe, be;
  logic [6:0] cases [9] = '{7'h40, 7'h60, 7'h50, 7'h52, 7'h54, 7'h5C, 7'h41, 7'h00, 7'h57};
  ocg_exp_t q[$];
  ocg_exp_t e;
  always #10 clock = ~clock;
  ocg_sysint_model ocg_sysint_model_inst (.en_allow(en_allow), .stop_mode(stop_mode),
    .crystal_pin(xpin), .pll_pin(ppin), .osc_en(osc_en));
  ocg_top #(.RC_HZ(5_000_000)) ocg_top_inst (.clock(clock), .rst(rst),
    .crystal_amp_input(xpin), .pll_clock_in(ppin), .crystal_amp_output(amp),
    .oscillator_enable_from_sysint(osc_en), .stop_mode(stop_mode), .wait_mode(wait_mode),
    .break_mode(break_mode), .stop_rc_disable(rc_dis), .stop_crystal_keepalive(keep),
    .base_select_pll(sel), .internal_rc_clock(rc), .monitor_clock(mon), .sysint_clock(sysc),
    .crystal_clock_out(xclk), .pll_reference_clock(pref), .base_clock_out(base),
    .bus_clock_out(bus));
  task automatic rng(input string what, input int lo, input int hi, input int seen);
    samples_checked++;
    if (seen < lo || seen > hi)
    begin
      n_fail++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : rng
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // Keep-alive and disable bits settle a cycle before stop is entered.
  task automatic run_case(input logic [6:0] m);
    @(posedge clock);
    #2 {en_allow, wait_mode, break_mode, rc_dis, keep, sel} = {m[6], m[4:0]};
    @(posedge clock);
    #2 stop_mode = m[5];
    repeat (24) @(posedge clock);
    q.push_back({(m[6] & ~m[5]) | (m[5] & m[1]) | m[3], ~m[5] | ~m[2] | m[3], m[0]});
    #2 win = 1'b1;
    repeat (96) @(posedge clock);
    #2 win = 1'b0;
    win_end = 1'b1;
    @(posedge clock);
    #2 win_end = 1'b0;
    $display("case %b done", m);
  endtask : run_case
  // Outputs are looked at on the falling edge, where they have settled since
  // the rising edge that launched them.
  always @(negedge clock)
  begin
    if (!rst)
    begin
      samples_checked++;
      if (mon !== rc || sysc !== rc || pref !== xclk)
      begin
        n_fail++;
        $display("[ERR] mirrored clocks expected equal seen %b%b%b %b%b", rc, mon, sysc, xclk, pref);
      end
    end
    nx += int'(win && xclk && !px);
    nr += int'(win && rc && !pr);
    nb += int'(win && base && !pb);
    nu += int'(win && bus && !pu);
    na += int'(win && amp && !pa);
    {px, pr, pb, pu, pa} = {xclk, rc, base, bus, amp};
    if (win_end)
    begin
      e = q.pop_front();
      xe = e.x ? 12 : 0;
      be = e.s ? 4 : (e.x ? 6 : 0);
      rng("crystal rises", xe - int'(xe > 0), xe + int'(xe > 0), nx);
      rng("rc rises", e.r ? 9 : 0, e.r ? 10 : 0, nr);
      rng("base rises", be - int'(be > 0), be + int'(be > 0), nb);
      rng("bus rises", be / 2 - int'(be > 0), be / 2 + int'(be > 0), nu);
      rng("amp rises", xe - int'(xe > 0), xe + int'(xe > 0), na);
      na = 0;
      nx = 0;
      nr = 0;
      nb = 0;
      nu = 0;
    end
  end
  initial
  begin
    void'($urandom(32'h153d84b0));
    repeat (20) @(posedge clock);
    #2 rst = 1'b0;
    foreach (cases[i])
      run_case(cases[i]);
    repeat (24)
      run_case(7'($urandom()));
    report_and_stop();
  end
  initial
  begin
    #300us;
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule : tb_ocg_top
